// *** include/spcfg_pkg.sv ***
package spcfg_pkg;
    // register addresses (12-bit register space)
    localparam logic [11:0] ADDR_PORT_CFG = 12'h000;
    localparam logic [11:0] ADDR_PART_IDENTIFIER = 12'h003;
    localparam logic [11:0] ADDR_READBACK = 12'h004;
    localparam logic [11:0] ADDR_NVM_PWR_HI = 12'ha13;
    localparam logic [11:0] ADDR_NVM_PWR_LO = 12'ha14;
    localparam logic [11:0] ADDR_NVM_UPDATE = 12'ha15;
    localparam logic [11:0] ADDR_NVM_END = 12'ha16;
    localparam logic [11:0] ADDR_NVM_STATE = 12'hb00;
    localparam logic [11:0] ADDR_NVM_INTEG = 12'hb01;
    localparam logic [11:0] ADDR_NVM_CTL1 = 12'hb02;
    localparam logic [11:0] ADDR_NVM_CTL2 = 12'hb03;
    // field positions
    localparam int BIT_OUT_PIN = 7;
    localparam int BIT_LSB_FIRST = 6;
    localparam int BIT_SOFT_RST = 5;
    localparam int BIT_RB_ACTIVE = 0;
    localparam int BIT_NVM_WREN = 0;
    localparam int BIT_NVM_LOAD = 1;
    localparam int BIT_NVM_STORE = 0;
    // reset values
    localparam logic [7:0] RST_PORT_CFG = 8'h00;
    localparam logic [7:0] RST_READBACK = 8'h00;
    localparam logic [7:0] RST_NVM_PWR_HI = 8'h02;
    localparam logic [7:0] RST_NVM_PWR_LO = 8'h30;
    localparam logic [7:0] RST_NVM_UPDATE = 8'h80;
    localparam logic [7:0] RST_NVM_END = 8'hff;
    localparam logic [7:0] RST_NVM_CTL = 8'h00;
    // arbitrary neutral identifier value
    localparam logic [7:0] PART_IDENTIFIER_DEFAULT = 8'h5a;
    // mask of writable bits in the port configuration register
    localparam logic [7:0] PORT_CFG_WMASK = 8'hcf;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
endpackage : spcfg_pkg

// *** include/cfg_bank_if.sv ***
`timescale 1ns/10ps
interface cfg_bank_if;
    logic load_defaults;
    logic load_nvm;
    logic [7:0] pwr_hi;
    logic [7:0] pwr_lo;
    logic [7:0] upd;
    logic [7:0] endm;
    logic [7:0] rb_sel;
    logic [7:0] active_rb;
    modport ctl (output load_defaults, output load_nvm, input pwr_hi,
        input pwr_lo, input upd, input endm, input rb_sel,
        input active_rb);
    modport bank (input load_defaults, input load_nvm, output pwr_hi,
        output pwr_lo, output upd, output endm, output rb_sel,
        output active_rb);
endinterface : cfg_bank_if

// *** src/nvm_instr_bank.sv ***
`timescale 1ns/10ps
// instruction-area storage (buffered only) and readback-select storage, buffered and active copies
module nvm_instr_bank (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic wr_en, // write strobe
    input wire logic [11:0] wr_addr, // write address
    input wire logic [7:0] wr_data, // write data
    input wire logic io_update, // copy buffered to active
    input wire logic [31:0] nvm_image, // image used on nvm load
    cfg_bank_if.bank bus // to control core
);
    logic [7:0] buf_q [5];
    logic [7:0] next_buf [5];
    logic [7:0] act_q;
    logic [7:0] next_act;
    localparam logic [7:0] RSTV [5] = '{spcfg_pkg::RST_NVM_PWR_HI,
        spcfg_pkg::RST_NVM_PWR_LO, spcfg_pkg::RST_NVM_UPDATE,
        spcfg_pkg::RST_NVM_END, spcfg_pkg::RST_READBACK};
    localparam logic [11:0] ADDRS [5] = '{spcfg_pkg::ADDR_NVM_PWR_HI,
        spcfg_pkg::ADDR_NVM_PWR_LO, spcfg_pkg::ADDR_NVM_UPDATE,
        spcfg_pkg::ADDR_NVM_END, spcfg_pkg::ADDR_READBACK};

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            next_buf[i] = buf_q[i];
            if (bus.load_defaults) begin
                next_buf[i] = RSTV[i];
            end else if (bus.load_nvm && i < 4) begin
                next_buf[i] = nvm_image[8*i +: 8];
            end else if (bus.load_nvm) begin
                next_buf[i] = RSTV[i];
            end else if (wr_en && wr_addr == ADDRS[i]) begin
                next_buf[i] = wr_data;
            end
        end
        next_act = act_q;
        // readback select only takes effect at the update
        if (bus.load_defaults || bus.load_nvm) begin
            next_act = spcfg_pkg::RST_READBACK;
        end else if (io_update) begin
            next_act = buf_q[4];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 5; i++) begin
                buf_q[i] <= RSTV[i];
            end
            act_q <= spcfg_pkg::RST_READBACK;
        end else begin
            buf_q <= next_buf;
            act_q <= next_act;
        end
    end

    assign bus.pwr_hi = buf_q[0];
    assign bus.pwr_lo = buf_q[1];
    assign bus.upd = buf_q[2];
    assign bus.endm = buf_q[3];
    assign bus.rb_sel = buf_q[4];
    assign bus.active_rb = act_q;
endmodule : nvm_instr_bank

// *** src/nvm_seq.sv ***
`timescale 1ns/10ps
// nvm transfer tracker: busy flag while a load or store runs
module nvm_seq #(
    parameter int OP_CYCLES = 16 // cycles an nvm operation takes
) (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic start_load, // begin load pulse
    input wire logic start_store, // begin store pulse
    output logic busy, // operation running
    output logic load_done, // load finished pulse
    output logic store_done // store finished pulse
);
    typedef enum logic [1:0] {IDLE, LOADING, STORING} seq_state_t;
    seq_state_t state;
    seq_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        load_done = 1'b0;
        store_done = 1'b0;
        case (state)
            IDLE: begin
                next_cnt = 16'(OP_CYCLES - 1);
                if (start_load) begin
                    next_state = LOADING;
                end else if (start_store) begin
                    next_state = STORING;
                end
            end
            LOADING, STORING: begin
                if (cnt == 16'h0000) begin
                    load_done = (state == LOADING);
                    store_done = (state == STORING);
                    next_state = IDLE;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= IDLE;
            cnt <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign busy = (state != IDLE);
endmodule : nvm_seq

// *** src/serial_port_config_regs.sv ***
`timescale 1ns/10ps
// Operation
// - spi: bit 7 set sends reads on serial_out_pin, else data pin
// - spi: bit 6 picks lsb-first with incrementing addresses
// - bit 5 starts soft reset, self-clears; loads nvm or defaults
// - read-only 8-bit part identifier; writes ignored
// - readback select bit 0: buffered when clear, active when set
module serial_port_config_regs #(
    parameter logic [7:0] PART_IDENTIFIER = spcfg_pkg::PART_IDENTIFIER_DEFAULT, // arbitrary
    parameter int NVM_OP_CYCLES = 16 // nvm operation length
) (
    input wire logic core_clk, // 20 MHz clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic i2c_mode, // port runs i2c framing
    input wire logic nvm_sel, // nvm select pin level
    input wire logic io_update, // buffered to active transfer
    input wire logic wr_en, // register write strobe
    input wire logic rd_en, // register read strobe
    input wire logic [11:0] addr, // register address
    input wire logic [7:0] wr_data, // write data
    input wire logic [31:0] nvm_image, // nvm instruction image
    input wire logic nvm_data_err, // nvm checksum fault
    input wire logic [7:0] ext_active_data, // active copy of other regs
    input wire logic [7:0] ext_buffer_data, // buffered copy of other regs
    output logic [7:0] rd_data, // read data, registered
    output logic rd_valid, // read data valid pulse
    output logic rd_on_serial_out, // reads leave on serial_out_pin
    output logic serial_out_pin_oe, // serial_out_pin driver enable
    output logic lsb_first, // lsb-first, incrementing addresses
    output logic soft_reset, // soft reset pulse
    output logic nvm_busy, // nvm transfer running
    output logic nvm_store_start // register to nvm store pulse
);
    logic [7:0] port_cfg;
    logic [7:0] next_port_cfg;
    logic nvm_wren;
    logic next_nvm_wren;
    logic load_req;
    logic next_load_req;
    logic store_req;
    logic next_store_req;
    logic integ_err;
    logic next_integ_err;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic load_start;
    logic store_go;
    logic load_done;
    logic store_done;

    cfg_bank_if cbus ();

    function automatic logic hit(input logic [11:0] a,
        input logic [11:0] target);
        hit = (a == target);
    endfunction : hit

    // soft reset from bit 5 with nvm_sel high, or a soft nvm load, reruns the nvm load
    assign soft_reset = port_cfg[spcfg_pkg::BIT_SOFT_RST];
    assign cbus.load_defaults = soft_reset && !nvm_sel;
    assign load_start = (soft_reset && nvm_sel) || load_req;
    assign cbus.load_nvm = load_done;
    // store is refused unless write enable is set
    assign store_go = store_req && nvm_wren && !nvm_busy;
    assign nvm_store_start = store_go;

    nvm_seq #(
        .OP_CYCLES(NVM_OP_CYCLES)
    ) u_seq (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start_load(load_start && !nvm_busy),
        .start_store(store_go),
        .busy(nvm_busy),
        .load_done(load_done),
        .store_done(store_done)
    );

    nvm_instr_bank u_bank (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en),
        .wr_addr(addr),
        .wr_data(wr_data),
        .io_update(io_update),
        .nvm_image(nvm_image),
        .bus(cbus.bank)
    );

    always_comb begin
        next_port_cfg = port_cfg;
        // soft reset bit clears itself the cycle after it is seen
        next_port_cfg[spcfg_pkg::BIT_SOFT_RST] = 1'b0;
        if (cbus.load_defaults) begin
            next_port_cfg = spcfg_pkg::RST_PORT_CFG;
        end else if (wr_en && hit(addr, spcfg_pkg::ADDR_PORT_CFG)) begin
            // mirror nibble stored as written; the host keeps it coherent
            next_port_cfg = wr_data & spcfg_pkg::PORT_CFG_WMASK;
            next_port_cfg[spcfg_pkg::BIT_SOFT_RST] =
                wr_data[spcfg_pkg::BIT_SOFT_RST];
        end
        next_nvm_wren = nvm_wren;
        next_load_req = load_req && nvm_busy;
        next_store_req = store_req;
        if (cbus.load_defaults) begin
            next_nvm_wren = 1'b0;
            next_store_req = 1'b0;
        end
        if (wr_en && hit(addr, spcfg_pkg::ADDR_NVM_CTL1)) begin
            next_nvm_wren = wr_data[spcfg_pkg::BIT_NVM_WREN];
            next_load_req = wr_data[spcfg_pkg::BIT_NVM_LOAD];
        end
        // load bit self-clears once the engine accepts it
        if (load_req && !nvm_busy) begin
            next_load_req = 1'b0;
        end
        if (store_done || (store_req && !nvm_wren)) begin
            next_store_req = 1'b0;
        end
        if (wr_en && hit(addr, spcfg_pkg::ADDR_NVM_CTL2)) begin
            next_store_req = wr_data[spcfg_pkg::BIT_NVM_STORE];
        end
        // error flag: a new fault wins over the clear by a fresh load
        next_integ_err = integ_err;
        if (load_start) begin
            next_integ_err = 1'b0;
        end
        if (nvm_data_err) begin
            next_integ_err = 1'b1;
        end
    end

    always_comb begin
        next_rd_valid = rd_en;
        next_rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                spcfg_pkg::ADDR_PORT_CFG: next_rd_data = port_cfg;
                spcfg_pkg::ADDR_PART_IDENTIFIER: next_rd_data = PART_IDENTIFIER;
                spcfg_pkg::ADDR_READBACK: next_rd_data =
                    cbus.active_rb[spcfg_pkg::BIT_RB_ACTIVE] ?
                    cbus.active_rb : cbus.rb_sel;
                spcfg_pkg::ADDR_NVM_PWR_HI: next_rd_data = cbus.pwr_hi;
                spcfg_pkg::ADDR_NVM_PWR_LO: next_rd_data = cbus.pwr_lo;
                spcfg_pkg::ADDR_NVM_UPDATE: next_rd_data = cbus.upd;
                spcfg_pkg::ADDR_NVM_END: next_rd_data = cbus.endm;
                spcfg_pkg::ADDR_NVM_STATE: next_rd_data =
                    {7'h00, nvm_busy};
                spcfg_pkg::ADDR_NVM_INTEG: next_rd_data =
                    {7'h00, integ_err};
                spcfg_pkg::ADDR_NVM_CTL1: next_rd_data =
                    {6'h00, load_req, nvm_wren};
                spcfg_pkg::ADDR_NVM_CTL2: next_rd_data =
                    {7'h00, store_req};
                default: begin
                    // other registers come from outside, bank per select
                    next_rd_data =
                        cbus.active_rb[spcfg_pkg::BIT_RB_ACTIVE] ?
                        ext_active_data : ext_buffer_data;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_cfg <= spcfg_pkg::RST_PORT_CFG;
            nvm_wren <= 1'b0;
            load_req <= 1'b0;
            store_req <= 1'b0;
            integ_err <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            port_cfg <= next_port_cfg;
            nvm_wren <= next_nvm_wren;
            load_req <= next_load_req;
            store_req <= next_store_req;
            integ_err <= next_integ_err;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // pin arrangement and bit order only matter in spi framing
    assign rd_on_serial_out = !i2c_mode &&
        port_cfg[spcfg_pkg::BIT_OUT_PIN];
    assign serial_out_pin_oe = rd_on_serial_out && rd_valid;
    assign lsb_first = !i2c_mode &&
        port_cfg[spcfg_pkg::BIT_LSB_FIRST];
endmodule : serial_port_config_regs

// *** tb/serial_port_config_regs_checker.sv ***
`timescale 1ns/10ps
module serial_port_config_regs_checker #(
    parameter logic [7:0] PART_IDENTIFIER = 8'h00, // identifier under check
    parameter int NVM_OP_CYCLES = 16 // nvm operation length
) (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic i2c_mode, // i2c framing
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [11:0] addr, // address
    input wire logic [7:0] wr_data, // write data
    input wire logic [7:0] rd_data, // read data
    input wire logic rd_valid, // read valid
    input wire logic rd_on_serial_out, // reads on out pin
    input wire logic lsb_first, // bit order
    input wire logic soft_reset, // soft reset pulse
    input wire logic nvm_busy, // nvm busy
    input wire logic nvm_store_start // store pulse
);
    logic [7:0] busy_cnt;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // a stuck busy would hide a dead transfer engine
    always_ff @(posedge core_clk) begin
        busy_cnt <= (sys_rst || !nvm_busy) ? 8'h00 : busy_cnt + 8'h01;
    end
    // out-pin select and bit order follow the config register read answer, spi only
    property p_pin_sel;
        rd_valid && $past(addr) == spcfg_pkg::ADDR_PORT_CFG |->
            rd_on_serial_out ==
            (!i2c_mode && rd_data[spcfg_pkg::BIT_OUT_PIN]);
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("out pin select");
    property p_lsb;
        rd_valid && $past(addr) == spcfg_pkg::ADDR_PORT_CFG |->
            lsb_first == (!i2c_mode && rd_data[spcfg_pkg::BIT_LSB_FIRST]);
    endproperty
    a_lsb: assert property (p_lsb) else $error("lsb first select");
    property p_srst;
        wr_en && addr == spcfg_pkg::ADDR_PORT_CFG && wr_data[5]
            |=> soft_reset ##1 !soft_reset;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse");
    property p_srst_src;
        $rose(soft_reset) |-> $past(wr_en);
    endproperty
    a_srst_src: assert property (p_srst_src) else $error("stray reset");
    property p_pid;
        rd_en && addr == spcfg_pkg::ADDR_PART_IDENTIFIER |=> rd_data == PART_IDENTIFIER;
    endproperty
    a_pid: assert property (p_pid) else $error("part_identifier value");
    property p_rdv;
        rd_en |=> rd_valid;
    endproperty
    a_rdv: assert property (p_rdv) else $error("read not answered");
    property p_store;
        nvm_store_start |=> nvm_busy;
    endproperty
    a_store: assert property (p_store) else $error("store not busy");
    property p_busy_len;
        nvm_busy |-> busy_cnt <= NVM_OP_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
endmodule : serial_port_config_regs_checker
bind serial_port_config_regs serial_port_config_regs_checker #(
    .PART_IDENTIFIER(PART_IDENTIFIER), .NVM_OP_CYCLES(NVM_OP_CYCLES)
) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .i2c_mode(i2c_mode),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .lsb_first(lsb_first),
    .rd_on_serial_out(rd_on_serial_out), .soft_reset(soft_reset),
    .nvm_busy(nvm_busy), .nvm_store_start(nvm_store_start)
);

// *** tb/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    input wire logic core_clk, // clock
    input wire logic [7:0] rd_data, // read data
    input wire logic serial_out_pin_oe, // out pin enable
    output logic wr_en, // write strobe
    output logic rd_en, // read strobe
    output logic [11:0] addr, // address
    output logic [7:0] wr_data // write data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wr_data = 8'h00;
    end
    // low nibble mirrors high so either bit order reads the same
    function automatic logic [7:0] mirror(input logic [3:0] hi);
        return {hi, hi[0], hi[1], hi[2], hi[3]};
    endfunction : mirror
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(negedge core_clk);
        wr_en = 1'b1;
        addr = a;
        wr_data = v;
        @(negedge core_clk);
        wr_en = 1'b0;
        wr_data = ~v;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v,
        output logic oe);
        @(negedge core_clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge core_clk);
        rd_en = 1'b0;
        v = rd_data;
        oe = serial_out_pin_oe;
    endtask : rd
endmodule : host_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    localparam logic [11:0] AL[11] = '{12'h000, 12'h003, 12'h004,
        12'ha13, 12'ha14, 12'ha15, 12'ha16, 12'hb00, 12'hb01, 12'hb02,
        12'hb03};
    // 9 also sets bit 4, which must always read back as zero
    localparam logic [3:0] HI[4] = '{4'h8, 4'h4, 4'hc, 4'h9};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic i2c_mode = 1'b0;
    logic nvm_sel = 1'b0;
    logic io_update = 1'b0;
    logic nvm_data_err = 1'b0;
    logic [31:0] nvm_image = 32'h0;
    logic [7:0] ext_act = 8'h00;
    logic [7:0] ext_buf = 8'h00;
    logic wr_en, rd_en, rd_valid, oe, rd_sout, soe, lsb, srst, busy, sst;
    logic [11:0] addr;
    logic [7:0] wr_data, rd_data, d, r8;
    int fail_count = 0;
    int n_tests = 0;
    always #25 core_clk = ~core_clk;
    serial_port_config_regs #(.NVM_OP_CYCLES(4)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .i2c_mode(i2c_mode),
        .nvm_sel(nvm_sel), .io_update(io_update), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .nvm_image(nvm_image), .nvm_data_err(nvm_data_err),
        .ext_active_data(ext_act), .ext_buffer_data(ext_buf),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_on_serial_out(rd_sout),
        .serial_out_pin_oe(soe), .lsb_first(lsb), .soft_reset(srst),
        .nvm_busy(busy), .nvm_store_start(sst)
    );
    host_model u_host (
        .core_clk(core_clk), .rd_data(rd_data), .serial_out_pin_oe(soe),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data)
    );
    function automatic logic [7:0] exp_rst(input logic [11:0] a);
        case (a)
            spcfg_pkg::ADDR_PORT_CFG: return spcfg_pkg::RST_PORT_CFG;
            spcfg_pkg::ADDR_PART_IDENTIFIER: return spcfg_pkg::PART_IDENTIFIER_DEFAULT;
            spcfg_pkg::ADDR_READBACK: return spcfg_pkg::RST_READBACK;
            spcfg_pkg::ADDR_NVM_PWR_HI: return spcfg_pkg::RST_NVM_PWR_HI;
            spcfg_pkg::ADDR_NVM_PWR_LO: return spcfg_pkg::RST_NVM_PWR_LO;
            spcfg_pkg::ADDR_NVM_UPDATE: return spcfg_pkg::RST_NVM_UPDATE;
            spcfg_pkg::ADDR_NVM_END: return spcfg_pkg::RST_NVM_END;
            spcfg_pkg::ADDR_NVM_CTL1: return spcfg_pkg::RST_NVM_CTL;
            default: return 8'h00;
        endcase
    endfunction : exp_rst
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask : chk1
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        u_host.rd(a, d, oe);
        chk8(d, e);
    endtask : rdc
    task automatic chk_rst;
        foreach (AL[i]) rdc(AL[i], exp_rst(AL[i]));
    endtask : chk_rst
    task automatic wait_idle;
        // the engine starts one edge after the strobe; idle before is no news
        @(negedge core_clk);
        chk1(busy, 1'b1);
        for (int i = 0; i < 40 && busy === 1'b1; i++) @(negedge core_clk);
        chk1(busy, 1'b0);
    endtask : wait_idle
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        void'($urandom(45680));
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_rst;
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            i2c_mode = m[0];
            foreach (HI[k]) begin
                u_host.wr(12'h000, u_host.mirror(HI[k]));
                rdc(12'h000, u_host.mirror(HI[k]) & 8'hcf);
                chk1(rd_sout, HI[k][3] & ~m[0]);
                chk1(oe, rd_sout);
                chk1(lsb, HI[k][2] & ~m[0]);
            end
        end
        i2c_mode = 1'b0;
        u_host.wr(12'h000, 8'h00);
        u_host.wr(12'h003, 8'($urandom));
        u_host.wr(12'hb00, 8'hff);
        u_host.wr(12'hb01, 8'hff);
        rdc(12'h003, spcfg_pkg::PART_IDENTIFIER_DEFAULT);
        rdc(12'hb00, 8'h00);
        rdc(12'hb01, 8'h00);
        $display("test port config done");
        for (int i = 0; i < 4; i++) begin
            r8 = 8'($urandom);
            u_host.wr(12'ha13 + 12'(i), r8);
            rdc(12'ha13 + 12'(i), r8);
        end
        ext_act = 8'($urandom);
        ext_buf = ~ext_act;
        u_host.wr(12'h004, 8'h01);
        rdc(12'h100, ext_buf);
        @(negedge core_clk);
        io_update = 1'b1;
        @(negedge core_clk);
        io_update = 1'b0;
        rdc(12'h100, ext_act);
        rdc(12'h004, 8'h01);
        $display("test readback done");
        u_host.wr(12'h000, u_host.mirror(4'h2));
        chk1(srst, 1'b1);
        chk_rst;
        nvm_sel = 1'b1;
        nvm_image = $urandom;
        u_host.wr(12'h000, u_host.mirror(4'h2));
        @(negedge core_clk);
        chk1(busy, 1'b1);
        wait_idle;
        for (int i = 0; i < 4; i++) begin
            rdc(12'ha13 + 12'(i), nvm_image[8*i +: 8]);
        end
        $display("test soft reset done");
        nvm_data_err = 1'b1;
        u_host.wr(12'hb02, 8'h02);
        wait_idle;
        nvm_data_err = 1'b0;
        rdc(12'hb02, 8'h00);
        rdc(12'hb01, 8'h01);
        u_host.wr(12'hb03, 8'h01);
        chk1(sst, 1'b0);
        rdc(12'hb03, 8'h00);
        u_host.wr(12'hb02, 8'h01);
        u_host.wr(12'hb03, 8'h01);
        chk1(sst, 1'b1);
        wait_idle;
        rdc(12'hb03, 8'h00);
        // a clean load clears the integrity flag again
        u_host.wr(12'hb02, 8'h02);
        wait_idle;
        rdc(12'hb01, 8'h00);
        $display("test nvm done");
        stop_test;
    end
    // the sequence needs well under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        stop_test;
    end
endmodule : tb_top
